// ===== rtl/dr_capture.sv
`timescale 1ns/100ps
`default_nettype none
module dr_capture #(
  parameter bit DUAL_RATE = 1'b0,
  parameter int unsigned SAMPLE_W = dr_pkg::SAMPLE_W,
  parameter int unsigned FIFO_DEPTH = dr_pkg::FIFO_DEPTH,
  parameter int unsigned HIST_AW = dr_pkg::HIST_AW
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic recorder_enable_setting_in,
  input wire logic capture_trigger_input_in,
  input wire logic sample_rate_select_in,
  input wire logic network_60hz_in,
  input wire logic [dr_pkg::MS_W-1:0] pretrigger_time_setting_in,
  input wire logic [dr_pkg::MS_W-1:0] after_trigger_time_setting_in,
  input wire logic [dr_pkg::MS_W-1:0] capture_cap_setting_in,
  input wire logic [5:0] analog_count_in,
  input wire logic [6:0] binary_count_in,
  input wire logic sample_valid_in,
  input wire logic [SAMPLE_W-1:0] sample_data_in,
  output logic sample_ready_out,
  input wire logic store_clear_in,
  output logic rec_valid_out,
  output logic [1:0] rec_kind_out,
  output logic [SAMPLE_W-1:0] rec_data_out,
  input wire logic rec_ready_in,
  output logic recording_out,
  output logic settings_warning_out,
  output logic record_refused_out,
  output logic data_lost_out,
  output logic [dr_pkg::BYTES_W-1:0] store_used_out
);
  localparam int unsigned CW = dr_pkg::CNT_W;
  localparam int unsigned BW = dr_pkg::BYTES_W;
  localparam int unsigned FW = SAMPLE_W + 2;
  localparam logic [$clog2(FIFO_DEPTH):0] FILL_LIMIT =
    ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH - dr_pkg::FILL_MARGIN);

  function automatic logic [3:0] rate_mult(input logic high,
                                           input logic hz60);
    logic [3:0] m;
    m = dr_pkg::RATE_MULT_BASE_50;
    case ({high, hz60})
      2'b00: m = dr_pkg::RATE_MULT_BASE_50;
      2'b01: m = dr_pkg::RATE_MULT_BASE_60;
      2'b10: m = dr_pkg::RATE_MULT_HIGH_50;
      2'b11: m = dr_pkg::RATE_MULT_HIGH_60;
      default: m = dr_pkg::RATE_MULT_BASE_50;
    endcase
    return m;
  endfunction

  // Milliseconds to samples, scaled by mult/5 (1.2 kHz is not integral)
  function automatic logic [CW-1:0] ms_to_samples(input logic [29:0] ms,
                                                  input logic [3:0] mult);
    logic [29:0] p;
    p = (ms * 30'(mult)) / dr_pkg::RATE_DIV;
    return p[CW-1:0];
  endfunction

  dr_pkg::dr_state_type state_q;
  logic high_rate, fits, strobe, armed, fire, emitting, end_trig;
  logic sample_ready_q, rearm_q, pend_q, cap_hit_q, warn_q, refused_q;
  logic lost_q, push_valid, fifo_in_ready;
  logic [3:0] mult, mult_q;
  logic [5:0] an_n;
  logic [6:0] bn_n;
  logic [9:0] bytes_per_ms;
  logic [29:0] dur_ms;
  logic [BW-1:0] est_bytes, used_q;
  logic [CW-1:0] target, pre_q, post_q, cap_q;
  logic [CW-1:0] trig_cnt_q, post_cnt_q, emit_cnt_q;
  logic [12:0] counts_q;
  logic [SAMPLE_W-1:0] hist_word;
  logic [FW-1:0] push_word;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  assign high_rate = DUAL_RATE && sample_rate_select_in;
  assign mult = rate_mult(high_rate, network_60hz_in);
  assign an_n = (analog_count_in > dr_pkg::MAX_ANALOG) ?
                dr_pkg::MAX_ANALOG : analog_count_in;
  assign bn_n = (binary_count_in > dr_pkg::MAX_BINARY) ?
                dr_pkg::MAX_BINARY : binary_count_in;
  assign bytes_per_ms = 10'(an_n) * dr_pkg::ANALOG_BYTES_PER_MS +
                        10'(bn_n) * dr_pkg::BINARY_BYTES_PER_MS;
  assign dur_ms = 30'(pretrigger_time_setting_in) +
                  30'(after_trigger_time_setting_in) +
                  30'(capture_cap_setting_in);
  // Worst-case size is charged, so a short record still reserves its cap
  assign est_bytes = BW'((30'(bytes_per_ms) * dur_ms * 30'(mult))
                         / dr_pkg::RATE_DIV);
  assign fits = (27'(used_q) + 27'(est_bytes)) <=
                27'(dr_pkg::STORE_BYTES);
  assign strobe = sample_valid_in && sample_ready_q;
  assign armed = (state_q == dr_pkg::ST_IDLE) && strobe &&
                 recorder_enable_setting_in && capture_trigger_input_in &&
                 rearm_q;
  assign fire = armed && fits;
  assign emitting = strobe && (emit_cnt_q < target) &&
                    ((state_q == dr_pkg::ST_TRIG) ||
                     (state_q == dr_pkg::ST_POST) ||
                     (state_q == dr_pkg::ST_DRAIN));
  assign end_trig = !capture_trigger_input_in ||
                    (trig_cnt_q >= cap_q);
  assign target = pre_q + trig_cnt_q + post_cnt_q;
  // Data leaves the ring pre+1 samples late, so the record opens with
  // the pre-trigger span while live samples keep filling the ring
  dr_history #(
    .W(SAMPLE_W),
    .AW(HIST_AW)
  ) u_history (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(strobe),
    .wr_data_in(sample_data_in),
    .back_in(HIST_AW'(pre_q + 1'b1)),
    .rd_data_out(hist_word)
  );

  always_comb
  begin
    push_valid = 1'b0;
    push_word = {dr_pkg::KIND_DAT, hist_word};
    case (state_q)
      dr_pkg::ST_HDR0:
      begin
        push_valid = 1'b1;
        push_word = {dr_pkg::KIND_CFG, SAMPLE_W'(counts_q)};
      end
      dr_pkg::ST_HDR1:
      begin
        push_valid = 1'b1;
        push_word = {dr_pkg::KIND_CFG,
                     SAMPLE_W'({mult_q, pre_q[11:0]})};
      end
      dr_pkg::ST_INFO:
      begin
        push_valid = 1'b1;
        push_word = {dr_pkg::KIND_INF,
                     SAMPLE_W'({lost_q, cap_hit_q})};
      end
      default:
      begin
        push_valid = pend_q;
        push_word = {dr_pkg::KIND_DAT, hist_word};
      end
    endcase
  end

  dr_fifo #(
    .W(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(push_valid),
    .in_data_in(push_word),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(rec_valid_out),
    .out_data_out({rec_kind_out, rec_data_out}),
    .out_ready_in(rec_ready_in),
    .level_out(fifo_level)
  );
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= dr_pkg::ST_IDLE;
    end
    else
    begin
      case (state_q)
        dr_pkg::ST_IDLE:
          if (fire)
            state_q <= dr_pkg::ST_HDR0;
        dr_pkg::ST_HDR0:
          if (fifo_in_ready)
            state_q <= dr_pkg::ST_HDR1;
        dr_pkg::ST_HDR1:
          if (fifo_in_ready)
            state_q <= dr_pkg::ST_TRIG;
        dr_pkg::ST_TRIG:
          if (strobe && end_trig)
            state_q <= dr_pkg::ST_POST;
        dr_pkg::ST_POST:
          if (strobe && (post_cnt_q >= post_q))
            state_q <= dr_pkg::ST_DRAIN;
        dr_pkg::ST_DRAIN:
          if (!pend_q && (emit_cnt_q == target))
            state_q <= dr_pkg::ST_INFO;
        dr_pkg::ST_INFO:
          if (fifo_in_ready)
            state_q <= dr_pkg::ST_IDLE;
        default:
          state_q <= dr_pkg::ST_IDLE;
      endcase
    end
  end

  // Section counters and settings frozen for the record
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pre_q <= dr_pkg::RST_CNT;
      post_q <= dr_pkg::RST_CNT;
      cap_q <= dr_pkg::RST_CNT;
      trig_cnt_q <= dr_pkg::RST_CNT;
      post_cnt_q <= dr_pkg::RST_CNT;
      emit_cnt_q <= dr_pkg::RST_CNT;
      mult_q <= dr_pkg::RATE_MULT_BASE_50;
      counts_q <= 13'h0000;
      cap_hit_q <= 1'b0;
    end
    else if (fire)
    begin
      pre_q <= ms_to_samples(30'(pretrigger_time_setting_in), mult);
      post_q <= ms_to_samples(30'(after_trigger_time_setting_in), mult);
      cap_q <= ms_to_samples(30'(capture_cap_setting_in), mult);
      trig_cnt_q <= CW'(1);
      post_cnt_q <= dr_pkg::RST_CNT;
      emit_cnt_q <= dr_pkg::RST_CNT;
      mult_q <= mult;
      counts_q <= {an_n, bn_n};
      cap_hit_q <= 1'b0;
    end
    else
    begin
      if (strobe && (state_q == dr_pkg::ST_TRIG))
      begin
        if (end_trig)
        begin
          post_cnt_q <= CW'(1);
          cap_hit_q <= capture_trigger_input_in;
        end
        else
          trig_cnt_q <= trig_cnt_q + 1'b1;
      end
      if (strobe && (state_q == dr_pkg::ST_POST) && (post_cnt_q < post_q))
        post_cnt_q <= post_cnt_q + 1'b1;
      if (emitting)
        emit_cnt_q <= emit_cnt_q + 1'b1;
    end
  end
  // Re-arm only after the trigger has been seen low
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rearm_q <= 1'b1;
    else if (!capture_trigger_input_in)
      rearm_q <= 1'b1;
    else if (armed)
      rearm_q <= 1'b0;
  end
  // Source is held off across header words and when the FIFO is nearly full
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sample_ready_q <= 1'b0;
      pend_q <= 1'b0;
    end
    else
    begin
      sample_ready_q <= (fifo_level <= FILL_LIMIT) && !fire &&
                        (state_q != dr_pkg::ST_HDR0) &&
                        (state_q != dr_pkg::ST_HDR1);
      pend_q <= emitting;
    end
  end
  // Store accounting and status flags; a new event wins over a clear for the flags, a firing record adds its size after a same-cycle clear
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      used_q <= dr_pkg::RST_BYTES;
      refused_q <= 1'b0;
      lost_q <= 1'b0;
      warn_q <= 1'b0;
    end
    else
    begin
      if (fire)
        used_q <= (store_clear_in ? dr_pkg::RST_BYTES : used_q) + est_bytes;
      else if (store_clear_in)
        used_q <= dr_pkg::RST_BYTES;
      if (armed && !fits)
        refused_q <= 1'b1;
      else if (store_clear_in)
        refused_q <= 1'b0;
      if (pend_q && !fifo_in_ready)
        lost_q <= 1'b1;
      else if (store_clear_in)
        lost_q <= 1'b0;
      warn_q <= (15'(pretrigger_time_setting_in) +
                 15'(after_trigger_time_setting_in)) >
                15'(capture_cap_setting_in);
    end
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      recording_out <= 1'b0;
    else
      recording_out <= fire || ((state_q != dr_pkg::ST_IDLE) &&
                       !((state_q == dr_pkg::ST_INFO) && fifo_in_ready));
  end
  assign sample_ready_out = sample_ready_q;
  assign settings_warning_out = warn_q;
  assign record_refused_out = refused_q;
  assign data_lost_out = lost_q;
  assign store_used_out = used_q;
endmodule // dr_capture
`default_nettype wire

// ===== rtl/dr_pkg.sv
package dr_pkg;

  localparam int unsigned MS_W = 14;
  localparam int unsigned CNT_W = 18;
  localparam int unsigned BYTES_W = 26;
  localparam int unsigned HIST_AW = 12;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned FILL_MARGIN = 3;

  // Channel limits per record
  localparam logic [5:0] MAX_ANALOG = 6'h20;
  localparam logic [6:0] MAX_BINARY = 7'h40;

  // Bytes per millisecond of record at the base rate on 50 Hz
  localparam logic [9:0] ANALOG_BYTES_PER_MS = 10'h007;
  localparam logic [9:0] BINARY_BYTES_PER_MS = 10'h002;

  // Record store bound: 12 MB
  localparam logic [BYTES_W-1:0] STORE_BYTES = 26'h0c00000;

  // Samples per millisecond times five, one per rate and network
  localparam logic [3:0] RATE_MULT_BASE_50 = 4'h5;
  localparam logic [3:0] RATE_MULT_BASE_60 = 4'h6;
  localparam logic [3:0] RATE_MULT_HIGH_50 = 4'ha;
  localparam logic [3:0] RATE_MULT_HIGH_60 = 4'hc;
  localparam logic [29:0] RATE_DIV = 30'h0000005;

  // Section tags on the record stream
  localparam logic [1:0] KIND_CFG = 2'h0;
  localparam logic [1:0] KIND_DAT = 2'h1;
  localparam logic [1:0] KIND_INF = 2'h2;

  // Values after reset, and default time settings (not used by the logic)
  localparam logic [BYTES_W-1:0] RST_BYTES = 26'h0000000;
  localparam logic [CNT_W-1:0] RST_CNT = 18'h00000;
  localparam logic [MS_W-1:0] DEFAULT_PRE_MS = 14'h00c8;
  localparam logic [MS_W-1:0] DEFAULT_POST_MS = 14'h00c8;
  localparam logic [MS_W-1:0] DEFAULT_CAP_MS = 14'h03e8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR0 = 3'b001,
    ST_HDR1 = 3'b010,
    ST_TRIG = 3'b011,
    ST_POST = 3'b100,
    ST_DRAIN = 3'b101,
    ST_INFO = 3'b110
  } dr_state_type;

endpackage

// ===== rtl/dr_fifo.sv
`timescale 1ns/100ps
`default_nettype none
// Depth must be a power of two; the output word sits in its own register
module dr_fifo #(
  parameter int unsigned W = 18,
  parameter int unsigned DEPTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in,
  output logic [$clog2(DEPTH):0] level_out
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic out_valid_q;
  logic [W-1:0] out_data_q;
  logic push;
  logic load;

  assign in_ready_out = (cnt_q < (AW+1)'(DEPTH));
  assign push = in_valid_in && in_ready_out;
  assign load = (cnt_q != '0) && (!out_valid_q || out_ready_in);
  assign out_valid_out = out_valid_q;
  assign out_data_out = out_data_q;
  assign level_out = cnt_q;

  always_ff @(posedge ref_clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr_q] <= in_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (load)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end
    else if (load)
    begin
      out_valid_q <= 1'b1;
      out_data_q <= mem[rd_ptr_q];
    end
    else if (out_ready_in)
    begin
      out_valid_q <= 1'b0;
    end
  end
endmodule // dr_fifo
`default_nettype wire

// ===== rtl/dr_history.sv
`timescale 1ns/100ps
`default_nettype none
// Circular history written on every accepted sample; the read returns
// the word written back_in samples before the current write.
module dr_history #(
  parameter int unsigned W = 16,
  parameter int unsigned AW = 12
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [W-1:0] wr_data_in,
  input wire logic [AW-1:0] back_in,
  output logic [W-1:0] rd_data_out
);
  logic [W-1:0] mem [2**AW];
  logic [AW-1:0] wr_ptr_q;
  logic [W-1:0] rd_q;

  assign rd_data_out = rd_q;

  always_ff @(posedge ref_clk_in)
  begin
    if (wr_en_in)
    begin
      mem[wr_ptr_q] <= wr_data_in;
      rd_q <= mem[wr_ptr_q - back_in];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_q <= '0;
    end
    else if (wr_en_in)
    begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end
endmodule // dr_history
`default_nettype wire

// ===== test/dr_capture_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module dr_capture_monitor #(
  parameter int unsigned SAMPLE_W = 16
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic recorder_enable_setting_in,
  input wire logic capture_trigger_input_in,
  input wire logic [dr_pkg::MS_W-1:0] pretrigger_time_setting_in,
  input wire logic [dr_pkg::MS_W-1:0] after_trigger_time_setting_in,
  input wire logic [dr_pkg::MS_W-1:0] capture_cap_setting_in,
  input wire logic sample_valid_in,
  input wire logic sample_ready_out,
  input wire logic store_clear_in,
  input wire logic rec_valid_out,
  input wire logic [1:0] rec_kind_out,
  input wire logic [SAMPLE_W-1:0] rec_data_out,
  input wire logic rec_ready_in,
  input wire logic recording_out,
  input wire logic settings_warning_out,
  input wire logic record_refused_out,
  input wire logic data_lost_out,
  input wire logic [dr_pkg::BYTES_W-1:0] store_used_out
);
  logic armed_q;
  logic rec_seen_q;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Low trigger wins over a record start so a same-cycle drop still rearms
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      armed_q <= 1'b1;
    else if (!capture_trigger_input_in)
      armed_q <= 1'b1;
    else if (recording_out && !rec_seen_q)
      armed_q <= 1'b0;
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rec_seen_q <= 1'b0;
    else
      rec_seen_q <= recording_out;
  end
  rec_hold_a: assert property (
    rec_valid_out && !rec_ready_in |=> rec_valid_out
      && $stable(rec_kind_out) && $stable(rec_data_out))
    else $error("record word changed while stalled");
  start_gate_a: assert property (
    $rose(recording_out) |-> $past(recorder_enable_setting_in
      && capture_trigger_input_in && sample_valid_in && sample_ready_out))
    else $error("record started without enable and trigger");
  warn_lag_a: assert property (
    $past(rst_n_in) |-> settings_warning_out ==
      $past(({1'b0, pretrigger_time_setting_in}
      + {1'b0, after_trigger_time_setting_in})
      > {1'b0, capture_cap_setting_in}))
    else $error("settings warning wrong");
  hdr_stall_a: assert property (
    $rose(recording_out) |-> !sample_ready_out [*2])
    else $error("samples taken during record header");
  rearm_need_a: assert property (
    $rose(recording_out) |-> $past(armed_q))
    else $error("second record without trigger release");
  store_bound_a: assert property (
    store_used_out <= dr_pkg::STORE_BYTES)
    else $error("store use above bound");
  store_grow_a: assert property (
    !$past(store_clear_in) |-> store_used_out >= $past(store_used_out))
    else $error("store use shrank without clear");
  refused_sticky_a: assert property (
    record_refused_out && !store_clear_in |=> record_refused_out)
    else $error("refused flag dropped");
  refuse_idle_a: assert property (
    $rose(record_refused_out) |-> !recording_out)
    else $error("refused record still recording");
  lost_sticky_a: assert property (
    data_lost_out && !store_clear_in |=> data_lost_out)
    else $error("lost flag dropped");
endmodule // dr_capture_monitor
bind dr_capture dr_capture_monitor #(.SAMPLE_W(SAMPLE_W)) u_mon (
  .ref_clk_in, .rst_n_in, .recorder_enable_setting_in,
  .capture_trigger_input_in, .pretrigger_time_setting_in,
  .after_trigger_time_setting_in, .capture_cap_setting_in,
  .sample_valid_in, .sample_ready_out, .store_clear_in, .rec_valid_out,
  .rec_kind_out, .rec_data_out, .rec_ready_in, .recording_out,
  .settings_warning_out, .record_refused_out, .data_lost_out,
  .store_used_out);
`default_nettype wire

// ===== test/dr_store_model.sv
`timescale 1ns/100ps
`default_nettype none
module dr_store_model (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic slow_in,
  input wire logic rec_valid_in,
  input wire logic [1:0] rec_kind_in,
  input wire logic [15:0] rec_data_in,
  output logic rec_ready_out,
  output logic [15:0] cfg0_out,
  output logic [15:0] cfg1_out,
  output logic [15:0] first_dat_out,
  output logic [15:0] inf_out,
  output logic [15:0] dat_cnt_out,
  output logic [7:0] inf_cnt_out
);
  logic [1:0] tick_q;
  logic cfg_seen_q;
  // Slow mode takes one word in four so the FIFO fills and backs up
  assign rec_ready_out = !slow_in || (tick_q == 2'h0);
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tick_q <= 2'h0;
      cfg_seen_q <= 1'b0;
      cfg0_out <= 16'h0000;
      cfg1_out <= 16'h0000;
      first_dat_out <= 16'h0000;
      inf_out <= 16'h0000;
      dat_cnt_out <= 16'h0000;
      inf_cnt_out <= 8'h00;
    end
    else
    begin
      tick_q <= tick_q + 2'h1;
      if (rec_valid_in && rec_ready_out)
      begin
        case (rec_kind_in)
          dr_pkg::KIND_CFG:
          begin
            cfg_seen_q <= 1'b1;
            if (!cfg_seen_q)
              cfg0_out <= rec_data_in;
            else
              cfg1_out <= rec_data_in;
            dat_cnt_out <= 16'h0000;
          end
          dr_pkg::KIND_DAT:
          begin
            if (dat_cnt_out == 16'h0000)
              first_dat_out <= rec_data_in;
            dat_cnt_out <= dat_cnt_out + 16'h0001;
          end
          default:
          begin
            cfg_seen_q <= 1'b0;
            inf_out <= rec_data_in;
            inf_cnt_out <= inf_cnt_out + 8'h01;
          end
        endcase
      end
    end
  end
endmodule // dr_store_model
`default_nettype wire

// ===== test/dr_capture_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module dr_capture_tb_top;
  logic ref_clk_in, rst_n_in, recorder_enable_setting_in, slow;
  logic capture_trigger_input_in, sample_rate_select_in, network_60hz_in;
  logic sample_valid_in, store_clear_in, sample_ready_out, rec_valid_out;
  logic rec_ready_in, recording_out, settings_warning_out;
  logic record_refused_out, data_lost_out;
  logic [dr_pkg::MS_W-1:0] pretrigger_time_setting_in;
  logic [dr_pkg::MS_W-1:0] after_trigger_time_setting_in;
  logic [dr_pkg::MS_W-1:0] capture_cap_setting_in;
  logic [5:0] analog_count_in;
  logic [6:0] binary_count_in;
  logic [1:0] rec_kind_out;
  logic [15:0] sample_data_in, rec_data_out, cfg0, cfg1, first_dat;
  logic [15:0] inf_word, dat_cnt, scnt;
  logic [7:0] inf_cnt;
  logic [dr_pkg::BYTES_W-1:0] store_used_out;
  logic [31:0] exp_used;
  int err_total, compares, cyc;
  dr_capture #(.DUAL_RATE(1'b1)) DUT (
    .ref_clk_in, .rst_n_in, .recorder_enable_setting_in,
    .capture_trigger_input_in, .sample_rate_select_in, .network_60hz_in,
    .pretrigger_time_setting_in, .after_trigger_time_setting_in,
    .capture_cap_setting_in, .analog_count_in, .binary_count_in,
    .sample_valid_in, .sample_data_in, .sample_ready_out, .store_clear_in,
    .rec_valid_out, .rec_kind_out, .rec_data_out, .rec_ready_in,
    .recording_out, .settings_warning_out, .record_refused_out,
    .data_lost_out, .store_used_out);
  dr_store_model u_store (.ref_clk_in, .rst_n_in, .slow_in(slow),
    .rec_valid_in(rec_valid_out), .rec_kind_in(rec_kind_out),
    .rec_data_in(rec_data_out), .rec_ready_out(rec_ready_in),
    .cfg0_out(cfg0), .cfg1_out(cfg1), .first_dat_out(first_dat),
    .inf_out(inf_word), .dat_cnt_out(dat_cnt), .inf_cnt_out(inf_cnt));
  initial
  begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  // Each word carries its own sample index so history order is visible
  always @(negedge ref_clk_in)
    sample_data_in = scnt;
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (sample_valid_in && sample_ready_out)
      scnt <= scnt + 16'h0001;
    if (cyc > 40000)
    begin
      err_total++;
      end_sim();
    end
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic set_cfg(logic [13:0] pre, logic [13:0] post,
    logic [13:0] cap);
    pretrigger_time_setting_in = pre;
    after_trigger_time_setting_in = post;
    capture_cap_setting_in = cap;
  endtask
  task automatic t_warn();
    @(negedge ref_clk_in);
    set_cfg(14'h12c, 14'h12c, 14'h1f4);
    repeat (3) @(negedge ref_clk_in);
    check("warn_on", 32'(settings_warning_out), 32'h1);
    set_cfg(14'h0fa, 14'h0fa, 14'h1f4);
    repeat (3) @(negedge ref_clk_in);
    check("warn_edge", 32'(settings_warning_out), 32'h0);
    $display("test warn done");
  endtask
  task automatic t_off();
    logic [7:0] ic;
    ic = inf_cnt;
    capture_trigger_input_in = 1'b1;
    repeat (30) @(negedge ref_clk_in);
    check("off_rec", 32'(recording_out), 32'h0);
    capture_trigger_input_in = 1'b0;
    recorder_enable_setting_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    check("off_inf", 32'(inf_cnt), 32'(ic));
    $display("test off done");
  endtask
  // A zero trigger length holds the trigger so the cap closes the record
  task automatic run_rec(string name, int pre, int post, int cap, int n,
    logic hz, logic sel, logic [5:0] an, logic [6:0] bn);
    int m, sp, ac, bc, k, e;
    logic [7:0] ic;
    logic [15:0] fire;
    m = sel ? (hz ? 12 : 10) : (hz ? 6 : 5);
    sp = pre * m / 5;
    e = sp + (cap + post) * m / 5;
    ac = an > 32 ? 32 : an;
    bc = bn > 64 ? 64 : bn;
    set_cfg(pre[13:0], post[13:0], cap[13:0]);
    network_60hz_in = hz;
    sample_rate_select_in = sel;
    analog_count_in = an;
    binary_count_in = bn;
    repeat (sp + 20) @(negedge ref_clk_in);
    ic = inf_cnt;
    capture_trigger_input_in = 1'b1;
    k = 0;
    while (k < (n > 0 ? n : 1))
    begin
      @(posedge ref_clk_in);
      if (sample_valid_in && sample_ready_out)
      begin
        if (k == 0)
          fire = sample_data_in;
        k++;
      end
    end
    @(negedge ref_clk_in);
    if (n > 0)
      capture_trigger_input_in = 1'b0;
    k = 0;
    while (inf_cnt == ic && k < 30000)
    begin
      @(negedge ref_clk_in);
      k++;
    end
    exp_used = exp_used + (ac * 7 + bc * 2) * (pre + post + cap) * m / 5;
    check("cfg0", 32'(cfg0), 32'({3'h0, ac[5:0], bc[6:0]}));
    check("cfg1", 32'(cfg1), 32'({m[3:0], sp[11:0]}));
    check("first", 32'(first_dat), 32'(fire - sp[15:0]));
    if (n > 0)
      check("dat", 32'(dat_cnt), sp + n + post * m / 5);
    else
      check("dat_cap", 32'(dat_cnt), e);
    check("inf_cap", 32'(inf_word[0]), 32'(n == 0));
    check("used", 32'(store_used_out), exp_used);
    check("lost", 32'(data_lost_out), 32'h0);
    if (n == 0)
    begin
      repeat (40) @(negedge ref_clk_in);
      check("held", 32'(inf_cnt), 32'(ic + 8'h01));
      check("held_rec", 32'(recording_out), 32'h0);
      capture_trigger_input_in = 1'b0;
    end
    $display("test %s done", name);
  endtask
  task automatic t_refuse();
    logic [25:0] u;
    u = store_used_out;
    capture_trigger_input_in = 1'b1;
    repeat (10) @(negedge ref_clk_in);
    check("refused", 32'(record_refused_out), 32'h1);
    check("no_rec", 32'(recording_out), 32'h0);
    check("kept", 32'(store_used_out), 32'(u));
    capture_trigger_input_in = 1'b0;
    store_clear_in = 1'b1;
    @(negedge ref_clk_in);
    store_clear_in = 1'b0;
    @(negedge ref_clk_in);
    check("cleared", 32'(record_refused_out), 32'h0);
    check("freed", 32'(store_used_out), 32'h0);
    $display("test refuse done");
  endtask
  initial
  begin
    rst_n_in = 1'b0;
    recorder_enable_setting_in = 1'b0;
    capture_trigger_input_in = 1'b0;
    sample_rate_select_in = 1'b0;
    network_60hz_in = 1'b0;
    sample_valid_in = 1'b0;
    store_clear_in = 1'b0;
    slow = 1'b0;
    set_cfg(14'h064, 14'h064, 14'h1f4);
    analog_count_in = 6'h01;
    binary_count_in = 7'h01;
    scnt = 16'h0000;
    exp_used = 32'h0;
    repeat (12) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    sample_valid_in = 1'b1;
    check("rst", 32'({recording_out, record_refused_out}), 32'h0);
    check("rst_used", 32'(store_used_out), 32'h0);
    t_off();
    t_warn();
    run_rec("release", 100, 100, 500, 50, 1'b0, 1'b0, 6'h05, 7'h03);
    slow = 1'b1;
    run_rec("clamp60", 100, 150, 500, 20, 1'b1, 1'b0, 6'h3f, 7'h7f);
    slow = 1'b0;
    run_rec("cap", 100, 100, 500, 0, 1'b1, 1'b1, 6'h02, 7'h02);
    run_rec("big", 1000, 1000, 10000, 10, 1'b0, 1'b1, 6'h20, 7'h40);
    t_refuse();
    end_sim();
  end
endmodule // dr_capture_tb_top
`default_nettype wire
